// ### rtl/uerx_defines.vh
// Purpose: Constants for the endpoint receive control/status block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Offsets are chosen locally
`ifndef UERX_DEFINES_VH
`define UERX_DEFINES_VH
`define UERX_OFF_CSR1 12'h000
`define UERX_OFF_CSR2 12'h004
`define UERX_OFF_CSR3 12'h008
`define UERX_OFF_MODE 12'h00c
`define UERX_OFF_STAT 12'h010
// CSR1 bit positions
`define UERX_B_TWEN 26
`define UERX_B_TGL 25
`define UERX_B_INCOMP 24
`define UERX_B_CLEAR_TOGGLE 23
`define UERX_B_STALLF 22
`define UERX_B_STALLC 21
`define UERX_B_FLUSH 20
`define UERX_B_DERR 19
`define UERX_B_OVR 18
`define UERX_B_FULL 17
`define UERX_B_RDY 16
// Field codes
`define UERX_PROT_CTRL 2'h0
`define UERX_PROT_ISO 2'h1
`define UERX_PROT_BULK 2'h2
`define UERX_PROT_INT 2'h3
`define UERX_SPD_HIGH 2'h1
`define UERX_SPD_FULL 2'h2
`define UERX_SPD_LOW 2'h3
`define UERX_FSZ_8 4'h3
`define UERX_FSZ_4K 4'hc
`define UERX_FSZ_8K 4'hd
`define UERX_NODATA_TRIES 2'h3
`endif

// ### rtl/uerx_ctrl.v
// Purpose: Per-endpoint receive control/status with host scheduling fields
// Assumes: USB link engine signals are synchronous one-cycle pulses on pclk
// Notes: APB slave, zero wait states, PSLVERR on unmapped addresses
`include "uerx_defines.vh"
`default_nettype none

// Behaviour
// - Host toggle readable, written only when enabled
// - Incomplete flag set on partial high-bandwidth packet
// - Clear-toggle write one zeros toggle
// - Device stall-sent flag set, software clears
// - Host stall-received flag plus interrupt event
// - Device answers STALL while send-stall set, except in ISO mode
// - In-request starts IN, clears on packet
// - Flush drops packet, clears ready, self-clears
// - Device ISO data error, cleared with ready
// - Host data error on CRC or bulk NAK timeout; only the timeout halts
// - Device ISO overrun flag, software clears
// - Host no-data error after three attempts
// - FIFO full reflects no free packet slot
// - Packet-received flag with event, software clears
// - Payload size is max payload times multiplier+1
// - Interval decode for interrupt and isochronous
// - Bulk NAK limit 2^(m-1), 0/1 disables
// - Speed and protocol field decodes
// - Host transactions use target endpoint number
// - Fourteen-bit byte count valid with ready
// - FIFO size codes reported read-only
module uerx_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire host_mode,
    input wire [3:0] rx_fifo_size_code,
    input wire [3:0] tx_fifo_size_code,
    input wire pkt_rx_ok,
    input wire pkt_rx_crc_err,
    input wire pkt_rx_partial,
    input wire pkt_overrun,
    input wire stall_tx_done,
    input wire stall_rx,
    input wire nak_rx,
    input wire no_data_attempt,
    input wire frame_tick,
    input wire toggle_advance,
    input wire [13:0] fifo_bytes,
    input wire fifo_slot_free,
    output reg send_stall,
    output reg in_req_start,
    output reg fifo_flush,
    output reg rx_halted,
    output reg event_irq,
    output reg [3:0] target_ep,
    output reg [1:0] tx_speed,
    output reg [1:0] tx_protocol,
    output reg [17:0] payload_size,
    output reg [15:0] interval_frames
);

// ---------------------------------------------------------------
// Functions
// ---------------------------------------------------------------
// Power of two of m-1, zero for m of 0
function [15:0] pow_m1;
    input [7:0] m;
    begin
        if (m == 8'h00 || m > 8'h10) begin
            pow_m1 = 16'h0000;
        end else begin
            pow_m1 = 16'h0001 << (m[4:0] - 5'h01);
        end
    end
endfunction

// Bytes for a FIFO size code, zero when reserved
function [13:0] fsz_bytes;
    input [3:0] c;
    begin
        if (c >= `UERX_FSZ_8 && c <= `UERX_FSZ_8K) begin
            fsz_bytes = 14'h0008 << (c - `UERX_FSZ_8);
        end else begin
            fsz_bytes = 14'h0000;
        end
    end
endfunction

// Bulk NAK limit; zero and one both turn the timeout off
function [15:0] nak_lim;
    input [7:0] m;
    begin
        if (m < 8'h02) begin
            nak_lim = 16'h0000;
        end else begin
            nak_lim = pow_m1(m);
        end
    end
endfunction

// Third attempt in a row without data
function last_try;
    input [1:0] t;
    begin
        last_try = t == `UERX_NODATA_TRIES - 2'h1;
    end
endfunction

// ---------------------------------------------------------------
// Registers
// ---------------------------------------------------------------
reg toggle_value_reg;
reg toggle_write_enable_reg;
reg incomplete_rx_flag_reg;
reg stall_flag_reg;
reg send_stall_ctrl_reg;
reg in_request_reg;
reg derr_flag_reg;
reg ovr_err_flag_reg;
reg packet_received_flag_reg;
reg [4:0] payload_multiplier_reg;
reg [10:0] rx_max_payload_reg;
reg [7:0] tx_interval_nak_limit_reg;
reg [1:0] tx_speed_reg;
reg [1:0] tx_proto_reg;
reg [3:0] tx_tep_reg;
reg [7:0] rx_interval_nak_limit_reg;
reg [1:0] rx_speed_reg;
reg [1:0] rx_proto_reg;
reg [3:0] rx_tep_reg;
reg iso_mode_reg;
reg [15:0] nak_frames_reg;
reg nak_active_reg;
reg [1:0] tries_reg;
reg in_req_q_reg;

wire wr_en = psel & penable & pwrite;
wire rd_sel = psel & ~pwrite;
wire a1 = paddr == `UERX_OFF_CSR1;
wire a2 = paddr == `UERX_OFF_CSR2;
wire a3 = paddr == `UERX_OFF_CSR3;
wire am = paddr == `UERX_OFF_MODE;
wire mapped = a1 | a2 | a3 | am;
// Status word is read-only, so only writes to it are refused
wire ast = paddr == `UERX_OFF_STAT;
wire w1 = wr_en & a1;
wire is_iso = host_mode ? (rx_proto_reg == `UERX_PROT_ISO) : iso_mode_reg;
wire is_bulk = rx_proto_reg == `UERX_PROT_BULK;
wire [15:0] nak_limit = nak_lim(rx_interval_nak_limit_reg);
// Halting clears the timer, so the timeout lasts one cycle
wire nak_timeout = host_mode & is_bulk & (nak_limit != 16'h0000) &
    nak_active_reg & (nak_frames_reg >= nak_limit);
wire rdy_clr = (w1 & ~pwdata[`UERX_B_RDY]) | (w1 & pwdata[`UERX_B_FLUSH]);

// No wait states: read data is captured in the setup cycle
assign pready = 1'b1;
assign pslverr = psel & penable & ~mapped & ~(ast & ~pwrite);

// ---------------------------------------------------------------
// Control and status state
// ---------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        toggle_value_reg <= 1'b0;
        toggle_write_enable_reg <= 1'b0;
        incomplete_rx_flag_reg <= 1'b0;
        stall_flag_reg <= 1'b0;
        send_stall_ctrl_reg <= 1'b0;
        in_request_reg <= 1'b0;
        derr_flag_reg <= 1'b0;
        ovr_err_flag_reg <= 1'b0;
        packet_received_flag_reg <= 1'b0;
        payload_multiplier_reg <= 5'h00;
        rx_max_payload_reg <= 11'h000;
        tx_interval_nak_limit_reg <= 8'h00;
        tx_speed_reg <= 2'h0;
        tx_proto_reg <= 2'h0;
        tx_tep_reg <= 4'h0;
        rx_interval_nak_limit_reg <= 8'h00;
        rx_speed_reg <= 2'h0;
        rx_proto_reg <= 2'h0;
        rx_tep_reg <= 4'h0;
        iso_mode_reg <= 1'b0;
        in_req_q_reg <= 1'b0;
    end else begin
        in_req_q_reg <= in_request_reg;
        // Data toggle: clear wins over a write and over link advance
        if (w1 && pwdata[`UERX_B_CLEAR_TOGGLE]) begin
            toggle_value_reg <= 1'b0;
        end else if (w1 && host_mode && pwdata[`UERX_B_TWEN]) begin
            toggle_value_reg <= pwdata[`UERX_B_TGL];
        end else if (toggle_advance) begin
            toggle_value_reg <= ~toggle_value_reg;
        end
        if (w1) begin
            toggle_write_enable_reg <= pwdata[`UERX_B_TWEN];
            payload_multiplier_reg <= pwdata[15:11];
            rx_max_payload_reg <= pwdata[10:0];
        end
        // Sticky flags: hardware set beats software clear
        if (pkt_rx_partial && is_iso) begin
            incomplete_rx_flag_reg <= 1'b1;
        end else if (w1 && !pwdata[`UERX_B_INCOMP]) begin
            incomplete_rx_flag_reg <= 1'b0;
        end
        if ((stall_tx_done && !host_mode) || (stall_rx && host_mode)) begin
            stall_flag_reg <= 1'b1;
        end else if (w1 && !pwdata[`UERX_B_STALLF]) begin
            stall_flag_reg <= 1'b0;
        end
        // Shared bit: send-stall in device mode, in-request in host mode
        if (w1 && !host_mode) begin
            send_stall_ctrl_reg <= pwdata[`UERX_B_STALLC];
        end
        if (pkt_rx_ok || !host_mode || nak_timeout) begin
            in_request_reg <= 1'b0;
        end else if (w1) begin
            in_request_reg <= pwdata[`UERX_B_STALLC];
        end
        if (pkt_rx_ok) begin
            packet_received_flag_reg <= 1'b1;
        end else if (rdy_clr) begin
            packet_received_flag_reg <= 1'b0;
        end
        // Data error: device clears with ready, host by software
        if ((pkt_rx_crc_err && (host_mode || is_iso)) || nak_timeout) begin
            derr_flag_reg <= 1'b1;
        end else if (!host_mode && rdy_clr) begin
            derr_flag_reg <= 1'b0;
        end else if (host_mode && w1 && !pwdata[`UERX_B_DERR]) begin
            derr_flag_reg <= 1'b0;
        end
        // Overrun in device, no-data error in host
        if ((pkt_overrun && !host_mode && is_iso) ||
            (no_data_attempt && host_mode && !is_iso &&
             last_try(tries_reg))) begin
            ovr_err_flag_reg <= 1'b1;
        end else if (w1 && !pwdata[`UERX_B_OVR]) begin
            ovr_err_flag_reg <= 1'b0;
        end
        if (wr_en && a2) begin
            tx_interval_nak_limit_reg <= pwdata[31:24];
            tx_speed_reg <= pwdata[23:22];
            tx_proto_reg <= pwdata[21:20];
            tx_tep_reg <= pwdata[19:16];
        end
        if (wr_en && a3) begin
            rx_interval_nak_limit_reg <= pwdata[15:8];
            rx_speed_reg <= pwdata[7:6];
            rx_proto_reg <= pwdata[5:4];
            rx_tep_reg <= pwdata[3:0];
        end
        if (wr_en && am) begin
            iso_mode_reg <= pwdata[0];
        end
    end
end

// ---------------------------------------------------------------
// Retry and NAK limit counters
// ---------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        nak_frames_reg <= 16'h0000;
        nak_active_reg <= 1'b0;
        tries_reg <= 2'h0;
    end else begin
        if (pkt_rx_ok || in_req_start) begin
            tries_reg <= 2'h0;
        end else if (no_data_attempt && !last_try(tries_reg)) begin
            tries_reg <= tries_reg + 2'h1;
        end else if (no_data_attempt) begin
            tries_reg <= 2'h0;
        end
        // Frames still counted when a NAK lands on the same tick
        if (pkt_rx_ok || in_req_start || nak_timeout) begin
            nak_active_reg <= 1'b0;
            nak_frames_reg <= 16'h0000;
        end else begin
            if (nak_rx) begin
                nak_active_reg <= 1'b1;
            end
            if (frame_tick && nak_active_reg && nak_frames_reg != 16'hffff) begin
                nak_frames_reg <= nak_frames_reg + 16'h0001;
            end
        end
    end
end

// ---------------------------------------------------------------
// Link-facing outputs
// ---------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        send_stall <= 1'b0;
        in_req_start <= 1'b0;
        fifo_flush <= 1'b0;
        rx_halted <= 1'b0;
        event_irq <= 1'b0;
        target_ep <= 4'h0;
        tx_speed <= 2'h0;
        tx_protocol <= 2'h0;
        payload_size <= 18'h00000;
        interval_frames <= 16'h0000;
    end else begin
        // No stall on isochronous endpoints
        send_stall <= send_stall_ctrl_reg & ~host_mode & ~iso_mode_reg;
        in_req_start <= in_request_reg & ~in_req_q_reg;
        fifo_flush <= w1 & pwdata[`UERX_B_FLUSH];
        if (nak_timeout) begin
            rx_halted <= 1'b1;
        end else if (in_req_start) begin
            rx_halted <= 1'b0;
        end
        event_irq <= pkt_rx_ok | (stall_rx & host_mode) |
            (no_data_attempt & host_mode & ~is_iso &
             last_try(tries_reg));
        target_ep <= tx_tep_reg;
        tx_speed <= tx_speed_reg;
        tx_protocol <= tx_proto_reg;
        payload_size <= rx_max_payload_reg * ({2'b00, payload_multiplier_reg} + 7'h01);
        if (tx_proto_reg == `UERX_PROT_INT && tx_speed_reg != `UERX_SPD_HIGH) begin
            interval_frames <= {8'h00, tx_interval_nak_limit_reg};
        end else if (tx_proto_reg == `UERX_PROT_BULK) begin
            interval_frames <= nak_lim(tx_interval_nak_limit_reg);
        end else begin
            interval_frames <= pow_m1(tx_interval_nak_limit_reg);
        end
    end
end

// ---------------------------------------------------------------
// APB read mux
// ---------------------------------------------------------------
// Flags that do not apply to the current transfer type read as zero
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
    end else if (rd_sel && !penable) begin
        if (a1) begin
            prdata <= {5'h00, toggle_write_enable_reg,
                host_mode & toggle_value_reg,
                incomplete_rx_flag_reg & is_iso,
                1'b0, stall_flag_reg,
                host_mode ? in_request_reg : send_stall_ctrl_reg,
                1'b0, derr_flag_reg & (host_mode | is_iso),
                ovr_err_flag_reg & (host_mode ? ~is_iso : is_iso),
                ~fifo_slot_free,
                packet_received_flag_reg,
                payload_multiplier_reg, rx_max_payload_reg};
        end else if (a2) begin
            prdata <= {tx_interval_nak_limit_reg, tx_speed_reg, tx_proto_reg, tx_tep_reg,
                2'h0, packet_received_flag_reg ? fifo_bytes : 14'h0000};
        end else if (a3) begin
            prdata <= {rx_fifo_size_code, tx_fifo_size_code, 8'h00,
                rx_interval_nak_limit_reg, rx_speed_reg, rx_proto_reg, rx_tep_reg};
        end else if (am) begin
            prdata <= {31'h00000000, iso_mode_reg};
        end else if (ast) begin
            prdata <= {4'h0, fsz_bytes(rx_fifo_size_code), fsz_bytes(tx_fifo_size_code)};
        end else begin
            prdata <= 32'h00000000;
        end
    end
end

endmodule // uerx_ctrl
`default_nettype wire

// ### verif/uerx_ctrl_checker.sv
// Purpose: Port assertions for the endpoint receive control block
// Assumes: One pclk domain, presetn asynchronous active low
// Notes: Field outputs are given two edges after the write
`include "uerx_defines.vh"
`default_nettype none
module uerx_ctrl_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic host_mode,
    input wire logic pkt_rx_ok,
    input wire logic stall_rx,
    input wire logic event_irq,
    input wire logic fifo_flush,
    input wire logic send_stall,
    input wire logic [3:0] target_ep,
    input wire logic [1:0] tx_speed,
    input wire logic [1:0] tx_protocol,
    input wire logic [17:0] payload_size,
    input wire logic [15:0] interval_frames
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // Write decode
    // ------
    logic wr1;
    logic wr2;
    logic wrm;
    logic iso_q;
    logic [17:0] exp_pay;
    assign wr1 = psel && penable && pwrite && paddr == `UERX_OFF_CSR1;
    assign wr2 = psel && penable && pwrite && paddr == `UERX_OFF_CSR2;
    assign wrm = psel && penable && pwrite && paddr == `UERX_OFF_MODE;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exp_pay <= 18'h00000;
            iso_q <= 1'b0;
        end else begin
            if (wr1) begin
                exp_pay <= pwdata[10:0] * (pwdata[15:11] + 5'h01);
            end
            if (wrm) begin
                iso_q <= pwdata[0];
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------
    // Assertions
    // ------
    a_stall_rx_irq: assert property (host_mode && stall_rx |=> event_irq)
        else $error("no event after stall received");
    a_packet_irq: assert property (pkt_rx_ok |=> event_irq)
        else $error("no event after packet");
    a_flush_pulse: assert property (wr1 && pwdata[20] |=> fifo_flush ##1 !fifo_flush)
        else $error("flush pulse wrong");
    a_send_stall: assert property (wr1 && !host_mode && !iso_q |->
        ##2 send_stall == $past(pwdata[21], 2))
        else $error("send stall not following write");
    a_payload_size: assert property (wr1 |-> ##2 payload_size == exp_pay)
        else $error("payload size wrong");
    a_target_ep: assert property (wr2 |-> ##2 target_ep == $past(pwdata[19:16], 2))
        else $error("target endpoint wrong");
    a_speed_proto: assert property (wr2 |=> ##1 {tx_speed, tx_protocol} == $past(pwdata[23:20], 2))
        else $error("speed or protocol wrong");
    a_poll_frames: assert property (wr2 && pwdata[21:20] == `UERX_PROT_INT &&
        pwdata[23:22] != `UERX_SPD_HIGH |-> ##2 interval_frames == {8'h00, $past(pwdata[31:24], 2)})
        else $error("polling interval wrong");
endmodule // uerx_ctrl_checker
bind uerx_ctrl uerx_ctrl_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .host_mode(host_mode), .pkt_rx_ok(pkt_rx_ok),
    .stall_rx(stall_rx), .event_irq(event_irq), .fifo_flush(fifo_flush),
    .send_stall(send_stall), .target_ep(target_ep), .tx_speed(tx_speed),
    .tx_protocol(tx_protocol), .payload_size(payload_size), .interval_frames(interval_frames)
);
`default_nettype wire

// ### verif/uerx_link_model.sv
// Purpose: Link engine and FIFO stand-in at the far side
// Assumes: Strobes from the bench, one cycle each
// Notes: Packet answer to an IN request comes late on purpose
`default_nettype none
module uerx_link_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [9:0] strobe,
    input wire logic send_stall,
    input wire logic in_req_start,
    input wire logic fifo_flush,
    output logic [9:0] pulse,
    output logic [13:0] fifo_bytes,
    output logic fifo_slot_free
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] reply;
    // One packet slot only, so full follows any content
    assign fifo_slot_free = fifo_bytes == 14'h0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse <= 10'h000;
            fifo_bytes <= 14'h0000;
            reply <= 3'h0;
        end else begin
            pulse <= strobe;
            pulse[4] <= strobe[4] && send_stall;
            reply <= {reply[1:0], in_req_start};
            if (reply[2]) pulse[0] <= 1'b1;
            if (pulse[0]) fifo_bytes <= fifo_bytes + 14'h0040;
            if (fifo_flush) fifo_bytes <= 14'h0000;
        end
    end
endmodule // uerx_link_model
`default_nettype wire

// ### verif/uerx_ctrl_bench.sv
// Purpose: Register-level tests of the endpoint receive control block
// Assumes: Zero-wait APB, link pulses made by the model
// Notes: Flags are kept by writing ones back
`include "uerx_defines.vh"
`default_nettype none
module uerx_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] csr1 = `UERX_OFF_CSR1;
    localparam logic [11:0] csr2 = `UERX_OFF_CSR2;
    logic pclk, presetn, psel, penable, pwrite, host_mode, err, pready, pslverr;
    logic fifo_slot_free, send_stall, in_req_start, fifo_flush, rx_halted, event_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, exp;
    logic [3:0] rxc, txc, target_ep;
    logic [9:0] strobe, pulse;
    logic [13:0] fifo_bytes;
    logic [1:0] tx_speed, tx_protocol;
    logic [17:0] payload_size;
    logic [15:0] interval_frames;
    logic [31:0] fw [5] = '{32'h05f7_0000, 32'h0557_0000, 32'h10a7_0000, 32'h0300_0000,
        32'h0127_0000};
    logic [31:0] fe [5] = '{32'h0000_05f7, 32'h0000_1057, 32'h0080_00a7, 32'h0000_0400,
        32'h0000_0027};
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    uerx_ctrl DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_mode(host_mode), .rx_fifo_size_code(rxc), .tx_fifo_size_code(txc),
        .pkt_rx_ok(pulse[0]), .pkt_rx_crc_err(pulse[1]), .pkt_rx_partial(pulse[2]),
        .pkt_overrun(pulse[3]), .stall_tx_done(pulse[4]), .stall_rx(pulse[5]),
        .nak_rx(pulse[6]), .no_data_attempt(pulse[7]), .frame_tick(pulse[8]),
        .toggle_advance(pulse[9]), .fifo_bytes(fifo_bytes), .fifo_slot_free(fifo_slot_free),
        .send_stall(send_stall), .in_req_start(in_req_start), .fifo_flush(fifo_flush),
        .rx_halted(rx_halted), .event_irq(event_irq), .target_ep(target_ep),
        .tx_speed(tx_speed), .tx_protocol(tx_protocol), .payload_size(payload_size),
        .interval_frames(interval_frames));
    uerx_link_model u_link (.pclk(pclk), .presetn(presetn), .strobe(strobe),
        .send_stall(send_stall), .in_req_start(in_req_start), .fifo_flush(fifo_flush),
        .pulse(pulse), .fifo_bytes(fifo_bytes), .fifo_slot_free(fifo_slot_free));
    // ------
    // Tasks
    // ------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, e);
    endtask
    task automatic ev(input logic [9:0] b);
        @(posedge pclk);
        strobe <= b;
        @(posedge pclk);
        strobe <= 10'h000;
        repeat (3) @(posedge pclk);
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Whole run is under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    // ------
    // Sequence
    // ------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, host_mode, paddr, pwdata, strobe} = '0;
        {rxc, txc} = 8'hd3;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk(csr1, 32'hffff_ffff, 32'h0000_0000);
        rchk(`UERX_OFF_CSR3, 32'hffff_ffff, 32'hd300_0000);
        rchk(`UERX_OFF_STAT, 32'h0000_3fff, 32'h0000_0008);
        chk({31'h0, err}, 32'h0000_0000);
        for (int c = 0; c < 16; c++) begin
            rxc <= 4'(c);
            exp = (c >= 3 && c <= 13) ? 32'h8 << (c + 11) : 32'h0;
            rchk(`UERX_OFF_STAT, 32'h0fff_c000, exp);
        end
        $display("fifo size codes done");
        host_mode <= 1'b1;
        apb(1'b1, csr1, 32'h0200_0000);
        rchk(csr1, 32'h0200_0000, 32'h0000_0000);
        apb(1'b1, csr1, 32'h0600_0000);
        rchk(csr1, 32'h0200_0000, 32'h0200_0000);
        apb(1'b1, csr1, 32'h0080_1200);
        rchk(csr1, 32'h0200_ffff, 32'h0000_1200);
        chk({14'h0, payload_size}, 32'h0000_0600);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, csr2, fw[i]);
            repeat (2) @(posedge pclk);
            chk({8'h0, interval_frames, tx_speed, tx_protocol, target_ep}, fe[i]);
        end
        $display("toggle and fields done");
        apb(1'b1, `UERX_OFF_CSR3, 32'h0000_0220);
        apb(1'b1, csr1, 32'h0020_0000);
        for (int i = 0; i < 20 && event_irq !== 1'b1; i++) @(posedge pclk);
        rchk(csr1, 32'h0023_0000, 32'h0003_0000);
        rchk(csr2, 32'h0000_3fff, 32'h0000_0040);
        apb(1'b1, csr1, 32'h0011_0000);
        rchk(csr1, 32'h0033_0000, 32'h0000_0000);
        ev(10'h020);
        rchk(csr1, 32'h0040_0000, 32'h0040_0000);
        apb(1'b1, csr1, 32'h0000_0000);
        rchk(csr1, 32'h0040_0000, 32'h0000_0000);
        ev(10'h080);
        ev(10'h080);
        rchk(csr1, 32'h0004_0000, 32'h0000_0000);
        ev(10'h080);
        rchk(csr1, 32'h0004_0000, 32'h0004_0000);
        ev(10'h040);
        ev(10'h100);
        chk({31'h0, rx_halted}, 32'h0000_0000);
        ev(10'h100);
        chk({31'h0, rx_halted}, 32'h0000_0001);
        rchk(csr1, 32'h0008_0000, 32'h0008_0000);
        $display("host receive done");
        host_mode <= 1'b0;
        apb(1'b1, csr1, 32'h0020_0000);
        repeat (2) @(posedge pclk);
        chk({31'h0, send_stall}, 32'h0000_0001);
        ev(10'h010);
        rchk(csr1, 32'h0040_0000, 32'h0040_0000);
        apb(1'b1, csr1, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk({31'h0, send_stall}, 32'h0000_0000);
        apb(1'b1, `UERX_OFF_MODE, 32'h0000_0001);
        ev(10'h00f);
        rchk(csr1, 32'h010d_0000, 32'h010d_0000);
        apb(1'b1, csr1, 32'h0000_0000);
        rchk(csr1, 32'h014d_0000, 32'h0000_0000);
        apb(1'b1, `UERX_OFF_MODE, 32'h0000_0000);
        ev(10'h00e);
        rchk(csr1, 32'h010c_0000, 32'h0000_0000);
        $display("device mode done");
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({err, rd[30:0]}, 32'h8000_0000);
        $display("unmapped access done");
        give_verdict();
    end
endmodule // uerx_ctrl_bench
`default_nettype wire
